// file: hw/charger_regs_consts.svh
// Register offsets, reset values, field positions and bus constants
`ifndef CHARGER_REGS_CONSTS_SVH
`define CHARGER_REGS_CONSTS_SVH
`define DEV_ADDR 7'h48
`define OFS_FLAGS 8'h00
`define OFS_CFG1 8'h02
`define OFS_CFG2 8'h03
`define OFS_CFG3 8'h04
`define OFS_CFG4 8'h05
`define OFS_CFG5 8'h06
`define OFS_UNLOCK 8'h11
`define OFS_NVM 8'h12
`define FLAGS_RST 8'h00
`define CFG_RST 8'h00
`define UNLOCK_RST 8'h00
`define NVM_RST 8'h00
`define FAULT_MSB 7
`define FAULT_LSB 4
`define COLD_BIT 5
`define HOT_BIT 4
`define PRE_MSB 7
`define PRE_LSB 6
`define COOL_MSB 5
`define COOL_LSB 3
`define WARM_MSB 2
`define WARM_LSB 0
`define TERM_BAD 3'h7
`define BYTE_DONE 4'h8
`define CNT_ZERO 4'h0
`endif

// file: hw/charger_regs_pkg.sv
// Types shared by the charger register slave
package charger_regs_pkg;
  typedef enum logic [6:0] {
    IDLE     = 7'h01,
    ADDR     = 7'h02,
    ADDR_ACK = 7'h04,
    WR_DATA  = 7'h08,
    WR_ACK   = 7'h10,
    RD_DATA  = 7'h20,
    RD_ACK   = 7'h40
  } link_state_t;
endpackage

// file: hw/charger_regs.sv
// Two-wire slave with status flags, config registers and fault pin
// How it works
// R1: A fault sets its status bit and pulls the fault pin low.
// R2: A warning sets its status bit but leaves the fault pin alone.
// R3: Reading the status register clears the bits it returned.
// R4: Fault pin released only once all fault bits are clear.
// R5: Status bits: overvolt, timeout, cold, hot, die hot, topoff, UV, open.
// R6: Only the upper four status bits are faults.
// R7: Fault pin stays low after the cause ends until status is read.
// R8: Slave answers at seven-bit address 0x48.
// R9: Config and NVM control reachable only after unlock is written.
// R10: Standard and fast rates, start/stop, auto-incrementing sequences.
// R11: Address byte arrives MSB first, direction bit last.
// R12: Matching address acknowledged by holding data low on ninth clock.
// R13: Every byte received as receiver is acknowledged.
// R14: Master acks each read byte but the last, which it leaves high.
// R15: After a not-acknowledged byte the slave releases the data line.
// R16: Precharge_and_cool_term_cfg bits 7:6 pick precharge current.
// R17: Precharge_and_cool_term_cfg bits 5:3 pick 0-10C termination; code 111 invalid.
// R18: Precharge_and_cool_term_cfg bits 2:0 pick 10-45C termination; code 111 invalid.
// R19: Battery too cold or too hot disables charging and sets fault.
// R20: First written byte is the sub-address, later bytes are data.
// R21: Pointer advances per byte; unmapped reads zero, writes ignored.
`timescale 1ns/10ps
`include "charger_regs_consts.svh"
module charger_regs (
  input wire logic clk,                // 25 MHz system clock
  input wire logic rstn,               // Async reset, active low
  input wire logic scl_in,             // Bus clock pin
  input wire logic sda_in,             // Bus data pin level
  output logic sda_out,                // Data drive value, always low
  output logic sda_oe,                 // High while pulling data low
  input wire logic [7:0] fault_cond,   // Detected conditions, same clock
  input wire logic [39:0] nvm_image,   // Stored config, cfg1 in low byte
  input wire logic nvm_valid,          // Pulse: load nvm_image
  output logic fault_out_n,            // Fault pin drive value, low
  output logic fault_oe,               // High while fault pin pulled low
  output logic charge_disable,         // Stop charging, battery temp
  output logic [1:0] precharge_current,// Precharge current code
  output logic term_cfg_invalid,       // A termination code is 111
  output logic [7:0] precharge_and_cool_term_cfg, // Config 1
  output logic [7:0] second_charge_cfg,  // Config 2
  output logic [7:0] third_charge_cfg,   // Config 3
  output logic [7:0] fourth_charge_cfg,  // Config 4
  output logic [7:0] fifth_charge_cfg,   // Config 5
  output logic [7:0] cfg_unlock,         // Unlock register
  output logic [7:0] nvm_control         // NVM control register
);

  charger_regs_pkg::link_state_t state;
  logic scl_m, scl_s, scl_p;
  logic sda_m, sda_s, sda_p;
  logic [3:0] cnt;
  logic [7:0] shreg, txsr, ptr, clr_mask, wr_ptr, wr_byte;
  logic [7:0] charger_flags;
  logic first, rw, nack, wr_stb, rd_clr;
  logic start, stop, scl_rise, scl_fall, unlocked;
  logic [7:0] cur_val;

  // Three-stage synchronisers; bus events compare the second and third stages
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_p <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      scl_p <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_p <= sda_s;
    end
  end

  // Bus events; data only moves while clock high for start/stop
  assign start = scl_s && scl_p && sda_p && !sda_s; // R10
  assign stop = scl_s && scl_p && !sda_p && sda_s; // R10
  assign scl_rise = scl_s && !scl_p;
  assign scl_fall = !scl_s && scl_p;
  assign unlocked = (cfg_unlock != `UNLOCK_RST);

  // Readback mux; locked config reads as zero like a hole
  function automatic logic [7:0] rd_val(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `OFS_FLAGS: v = charger_flags;
      `OFS_CFG1: v = unlocked ? precharge_and_cool_term_cfg : 8'h00; // R9
      `OFS_CFG2: v = unlocked ? second_charge_cfg : 8'h00;
      `OFS_CFG3: v = unlocked ? third_charge_cfg : 8'h00;
      `OFS_CFG4: v = unlocked ? fourth_charge_cfg : 8'h00;
      `OFS_CFG5: v = unlocked ? fifth_charge_cfg : 8'h00;
      `OFS_UNLOCK: v = cfg_unlock;
      `OFS_NVM: v = unlocked ? nvm_control : 8'h00;
      default: v = 8'h00; // R21
    endcase
    return v;
  endfunction

  assign cur_val = rd_val(ptr);

  // Byte engine; drive changes only after clock falls
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= charger_regs_pkg::IDLE;
      cnt <= `CNT_ZERO;
      shreg <= 8'h00;
      txsr <= 8'h00;
      ptr <= 8'h00;
      clr_mask <= 8'h00;
      wr_ptr <= 8'h00;
      wr_byte <= 8'h00;
      first <= 1'b0;
      rw <= 1'b0;
      nack <= 1'b0;
      wr_stb <= 1'b0;
      rd_clr <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      rd_clr <= 1'b0;
      if (start) begin
        state <= charger_regs_pkg::ADDR; // R10
        cnt <= `CNT_ZERO;
        sda_oe <= 1'b0;
      end else if (stop) begin
        state <= charger_regs_pkg::IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        case (state)
          charger_regs_pkg::ADDR, charger_regs_pkg::WR_DATA: begin
            shreg <= {shreg[6:0], sda_s}; // R11
            cnt <= cnt + 4'h1;
          end
          charger_regs_pkg::RD_DATA: cnt <= cnt + 4'h1;
          charger_regs_pkg::RD_ACK: nack <= sda_s; // R14
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state)
          charger_regs_pkg::ADDR: begin
            if (cnt == `BYTE_DONE) begin
              if (shreg[7:1] == `DEV_ADDR) begin // R8
                sda_oe <= 1'b1; // R12
                rw <= shreg[0]; // R11
                state <= charger_regs_pkg::ADDR_ACK;
              end else begin
                state <= charger_regs_pkg::IDLE;
              end
            end
          end
          charger_regs_pkg::ADDR_ACK: begin
            cnt <= `CNT_ZERO;
            first <= 1'b1;
            if (rw) begin
              txsr <= cur_val;
              sda_oe <= ~cur_val[7];
              ptr <= ptr + 8'h01; // R21
              state <= charger_regs_pkg::RD_DATA;
              if (ptr == `OFS_FLAGS) begin
                rd_clr <= 1'b1; // R3
                clr_mask <= cur_val;
              end
            end else begin
              sda_oe <= 1'b0;
              state <= charger_regs_pkg::WR_DATA;
            end
          end
          charger_regs_pkg::WR_DATA: begin
            if (cnt == `BYTE_DONE) begin
              cnt <= `CNT_ZERO;
              sda_oe <= 1'b1; // R13
              state <= charger_regs_pkg::WR_ACK;
              if (first) begin
                ptr <= shreg; // R20
                first <= 1'b0;
              end else begin
                wr_stb <= 1'b1; // R20
                wr_ptr <= ptr;
                wr_byte <= shreg;
                ptr <= ptr + 8'h01; // R21
              end
            end
          end
          charger_regs_pkg::WR_ACK: begin
            sda_oe <= 1'b0;
            state <= charger_regs_pkg::WR_DATA;
          end
          charger_regs_pkg::RD_DATA: begin
            if (cnt == `BYTE_DONE) begin
              sda_oe <= 1'b0;
              state <= charger_regs_pkg::RD_ACK;
            end else if (cnt != `CNT_ZERO) begin
              txsr <= {txsr[6:0], 1'b0};
              sda_oe <= ~txsr[6];
            end
          end
          charger_regs_pkg::RD_ACK: begin
            cnt <= `CNT_ZERO;
            if (nack) begin
              state <= charger_regs_pkg::IDLE; // R15
            end else begin
              txsr <= cur_val;
              sda_oe <= ~cur_val[7];
              ptr <= ptr + 8'h01; // R21
              state <= charger_regs_pkg::RD_DATA;
              if (ptr == `OFS_FLAGS) begin
                rd_clr <= 1'b1; // R3
                clr_mask <= cur_val;
              end
            end
          end
          default: state <= charger_regs_pkg::IDLE;
        endcase
      end
    end
  end

  // Sticky flags; a new event beats the read clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      charger_flags <= `FLAGS_RST;
    end else begin
      charger_flags <= (charger_flags & ~(rd_clr ? clr_mask : 8'h00))
                       | fault_cond; // R1 R2 R3 R5 R7
    end
  end

  // Open-drain pins with value held low and only the enable moving, plus registered charge_disable
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fault_oe <= 1'b0;
      fault_out_n <= 1'b0;
      sda_out <= 1'b0;
      charge_disable <= 1'b0;
    end else begin
      fault_oe <= |charger_flags[`FAULT_MSB:`FAULT_LSB]; // R1 R4 R6
      fault_out_n <= 1'b0;
      sda_out <= 1'b0;
      charge_disable <= fault_cond[`COLD_BIT] | fault_cond[`HOT_BIT]; // R19
    end
  end

  // Config registers; NVM load wins over a bus write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      precharge_and_cool_term_cfg <= `CFG_RST;
      second_charge_cfg <= `CFG_RST;
      third_charge_cfg <= `CFG_RST;
      fourth_charge_cfg <= `CFG_RST;
      fifth_charge_cfg <= `CFG_RST;
      cfg_unlock <= `UNLOCK_RST;
      nvm_control <= `NVM_RST;
    end else if (nvm_valid) begin
      precharge_and_cool_term_cfg <= nvm_image[7:0];
      second_charge_cfg <= nvm_image[15:8];
      third_charge_cfg <= nvm_image[23:16];
      fourth_charge_cfg <= nvm_image[31:24];
      fifth_charge_cfg <= nvm_image[39:32];
    end else if (wr_stb) begin
      case (wr_ptr)
        `OFS_UNLOCK: cfg_unlock <= wr_byte;
        `OFS_CFG1: if (unlocked) precharge_and_cool_term_cfg <= wr_byte; // R9
        `OFS_CFG2: if (unlocked) second_charge_cfg <= wr_byte; // R9
        `OFS_CFG3: if (unlocked) third_charge_cfg <= wr_byte;
        `OFS_CFG4: if (unlocked) fourth_charge_cfg <= wr_byte;
        `OFS_CFG5: if (unlocked) fifth_charge_cfg <= wr_byte;
        `OFS_NVM: if (unlocked) nvm_control <= wr_byte; // R9
        default: ; // R21
      endcase
    end
  end

  // Field decode; bad code flagged, the charger loop picks a fallback
  assign precharge_current =
    precharge_and_cool_term_cfg[`PRE_MSB:`PRE_LSB]; // R16
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      term_cfg_invalid <= 1'b0;
    end else begin
      term_cfg_invalid <= // R17 R18
        (precharge_and_cool_term_cfg[`COOL_MSB:`COOL_LSB] == `TERM_BAD) ||
        (precharge_and_cool_term_cfg[`WARM_MSB:`WARM_LSB] == `TERM_BAD);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  AST_FAULT_PIN: assert property ( // R1
    |fault_cond[`FAULT_MSB:`FAULT_LSB] |-> ##2 fault_oe)
    else $error("fault did not pull pin low");
  AST_WARN_ONLY: assert property ( // R2
    (charger_flags[`FAULT_MSB:`FAULT_LSB] == 4'h0) |=> !fault_oe)
    else $error("warning drove fault pin");
  AST_READ_CLEAR: assert property ( // R3
    rd_clr |=> ((charger_flags & clr_mask & ~$past(fault_cond)) == 8'h00))
    else $error("status read did not clear");
  AST_HOLD_PIN: assert property ( // R7
    (fault_oe && !$past(rd_clr) && fault_cond == 8'h00) |=> fault_oe)
    else $error("fault pin released without read");
  AST_ADDR_ACK: assert property ( // R12
    $rose(state == charger_regs_pkg::ADDR_ACK) |->
      sda_oe && ($past(shreg[7:1]) == `DEV_ADDR))
    else $error("address ack wrong");
  AST_BYTE_ACK: assert property ( // R13
    state == charger_regs_pkg::WR_ACK |-> sda_oe)
    else $error("written byte not acked");
  AST_NACK_FREE: assert property ( // R15
    (state == charger_regs_pkg::RD_ACK && scl_fall && nack && !start
      && !stop) |=> !sda_oe && state == charger_regs_pkg::IDLE)
    else $error("data not released after nack");
  AST_LOCKED: assert property ( // R9
    (wr_stb && !unlocked && !nvm_valid) |=>
      $stable(precharge_and_cool_term_cfg) && $stable(nvm_control))
    else $error("locked config changed");
  AST_PTR_STEP: assert property ( // R21
    (state == charger_regs_pkg::WR_DATA && scl_fall && !start && !stop
      && cnt == `BYTE_DONE && !first) |=> ptr == $past(ptr) + 8'h01)
    else $error("pointer did not advance");
  AST_TEMP_STOP: assert property ( // R19
    (fault_cond[`COLD_BIT] || fault_cond[`HOT_BIT]) |=> charge_disable &&
      (charger_flags[`COLD_BIT] || charger_flags[`HOT_BIT]))
    else $error("temperature fault missed");

  COV_WRITE: cover property (wr_stb && wr_ptr == `OFS_CFG1 && unlocked);
  COV_STATUS_READ: cover property (rd_clr && clr_mask[7]);
  COV_READ_NACK: cover property (
    state == charger_regs_pkg::RD_ACK && scl_fall && nack);

endmodule

// file: sim/i2c_host_model.sv
// Two-wire bus master model standing in for the host controller
`timescale 1ns/10ps
module i2c_host_model (
  input wire logic clk, // Paces the bus bits
  input wire logic sda, // Resolved data wire level
  output logic scl,     // Bus clock, high while idle
  output logic sda_oe   // High while pulling data low
);
  // Idle bus: clock high, data released
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // Wait n clocks, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One bit, 5 clocks low and 3 high; the long low phase lets the
  // slave finish moving its drive before the clock rises
  task automatic bit_x(input logic v, output logic got);
    sda_oe = ~v;
    tick(4);
    scl = 1'b1;
    tick(2);
    got = sda;
    tick(1);
    scl = 1'b0;
    tick(1);
  endtask
  // Start or repeated start: data falls while clock is high
  task automatic start_cond();
    sda_oe = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_oe = 1'b1;
    tick(4);
    scl = 1'b0;
    tick(1);
  endtask
  // Stop: data rises while clock is high
  task automatic stop_cond();
    sda_oe = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_oe = 1'b0;
    tick(4);
  endtask
  // Byte out, MSB first, direction bit last in an address byte
  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  // Byte in; acked unless it is the last one
  task automatic recv(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, b[i]);
    bit_x(last, r);
  endtask
endmodule

// file: sim/charger_i2c_status_config_regs_tb.sv
// Self-checking bench for the charger register slave
`timescale 1ns/10ps
`include "charger_regs_consts.svh"
module charger_i2c_status_config_regs_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] fault_cond = 8'h00;
  logic [39:0] nvm_image = 40'h00;
  logic nvm_valid = 1'b0;
  logic scl, m_oe, sda_w, sda_out, sda_oe, fault_out_n, fault_oe;
  logic charge_disable, term_inv;
  logic [1:0] pre_cur;
  logic [7:0] cfg_q [2:6];
  logic [7:0] unl_q, nvmc_q;
  logic [7:0] mdl [0:255];
  int err_total = 0;
  int n_checks = 0;
  // 25 MHz clock; both parties may only pull the data wire low
  always #20 clk = ~clk;
  assign sda_w = ~(sda_oe | m_oe);
  charger_regs u_dut (.clk(clk), .rstn(rstn), .scl_in(scl),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
    .fault_cond(fault_cond), .nvm_image(nvm_image),
    .nvm_valid(nvm_valid), .fault_out_n(fault_out_n),
    .fault_oe(fault_oe), .charge_disable(charge_disable),
    .precharge_current(pre_cur), .term_cfg_invalid(term_inv),
    .precharge_and_cool_term_cfg(cfg_q[2]),
    .second_charge_cfg(cfg_q[3]), .third_charge_cfg(cfg_q[4]),
    .fourth_charge_cfg(cfg_q[5]), .fifth_charge_cfg(cfg_q[6]),
    .cfg_unlock(unl_q), .nvm_control(nvmc_q));
  i2c_host_model u_host (.clk(clk), .sda(sda_w), .scl(scl), .sda_oe(m_oe));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Registers behind the unlock gate
  function automatic bit gated(input logic [7:0] a);
    return (a >= 8'h02 && a <= 8'h06) || a == `OFS_NVM;
  endfunction
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    if (mdl[`OFS_UNLOCK] == 8'h00 && gated(a)) return 8'h00;
    return mdl[a];
  endfunction
  // Write transfer; the model keeps only writes the device honours
  task automatic wr(input logic [7:0] sub, input logic [7:0] d[$]);
    logic ack;
    u_host.start_cond();
    u_host.send({`DEV_ADDR, 1'b0}, ack);
    chk({7'h00, ack}, 8'h01);
    u_host.send(sub, ack);
    chk({7'h00, ack}, 8'h01);
    foreach (d[i]) begin
      u_host.send(d[i], ack);
      chk({7'h00, ack}, 8'h01);
      if (sub == `OFS_UNLOCK || (mdl[`OFS_UNLOCK] != 8'h00 && gated(sub)))
        mdl[sub] = d[i];
      sub++;
    end
    u_host.stop_cond();
  endtask
  // Pointer write, repeated start, then n bytes read back
  task automatic rd(input logic [7:0] sub, input int n);
    logic ack;
    logic [7:0] b;
    u_host.start_cond();
    u_host.send({`DEV_ADDR, 1'b0}, ack);
    chk({7'h00, ack}, 8'h01);
    u_host.send(sub, ack);
    chk({7'h00, ack}, 8'h01);
    u_host.start_cond();
    u_host.send({`DEV_ADDR, 1'b1}, ack);
    chk({7'h00, ack}, 8'h01);
    for (int i = 0; i < n; i++) begin
      u_host.recv(i == n - 1, b);
      chk(b, exp_rd(sub));
      if (sub == `OFS_FLAGS) mdl[0] = 8'h00;
      sub++;
    end
    // Past the point where a wrongly loaded next byte would drive
    tick(4);
    chk({7'h00, sda_oe}, 8'h00);
    u_host.stop_cond();
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Cut a hang short
  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    conclude();
  end
  // Main sequence
  initial begin
    logic ack;
    logic [7:0] pat;
    logic [7:0] q[$];
    void'($urandom(7312));
    for (int i = 0; i < 256; i++) mdl[i] = 8'h00;
    tick(12);
    rstn = 1'b1;
    tick(4);
    chk({7'h00, fault_oe}, 8'h00);
    chk({7'h00, sda_out}, 8'h00);
    rd(`OFS_UNLOCK, 2);
    $display("test reset done");
    nvm_image = {8'($urandom), 32'($urandom)};
    nvm_valid = 1'b1;
    tick(1);
    nvm_valid = 1'b0;
    for (int k = 2; k <= 6; k++) mdl[k] = nvm_image[8*(k-2)+:8];
    tick(2);
    for (int k = 2; k <= 6; k++) chk(cfg_q[k], mdl[k]);
    rd(8'h02, 5);
    wr(`OFS_UNLOCK, {8'hA5, 8'h3C});
    chk(unl_q, mdl[`OFS_UNLOCK]);
    chk(nvmc_q, mdl[`OFS_NVM]);
    rd(8'h02, 5);
    $display("test unlock done");
    // Every code of all three precharge_and_cool_term_cfg fields
    for (int c = 0; c < 8; c++) begin
      pat = {c[1:0], c[2:0], 3'(7 - c)};
      wr(8'h02, {pat});
      tick(3);
      chk({6'h00, pre_cur}, {6'h00, pat[7:6]});
      chk({7'h00, term_inv}, {7'h00, c == 7 || c == 0});
    end
    q = {};
    repeat (5) q.push_back(8'($urandom));
    wr(8'h02, q);
    tick(3);
    for (int k = 2; k <= 6; k++) chk(cfg_q[k], mdl[k]);
    rd(8'h02, 5);
    wr(`OFS_UNLOCK, {8'h00});
    wr(8'h03, {8'h5A});
    wr(`OFS_NVM, {8'hC3});
    chk(nvmc_q, mdl[`OFS_NVM]);
    wr(`OFS_UNLOCK, {8'h3C});
    rd(8'h03, 1);
    chk(unl_q, mdl[`OFS_UNLOCK]);
    rd(`OFS_UNLOCK, 2);
    wr(8'h06, {8'h77, 8'h99});
    wr(`OFS_FLAGS, {8'hFF});
    rd(8'h06, 3);
    rd(`OFS_FLAGS, 1);
    $display("test config done");
    u_host.start_cond();
    u_host.send({7'h49, 1'b0}, ack);
    chk({7'h00, ack}, 8'h00);
    u_host.stop_cond();
    $display("test address done");
    // Each status bit alone, then a random mix
    for (int i = 0; i < 9; i++) begin
      pat = (i < 8) ? 8'h01 << i : 8'($urandom);
      fault_cond = pat;
      tick(2);
      chk({7'h00, charge_disable}, {7'h00, pat[5] | pat[4]});
      fault_cond = 8'h00;
      mdl[0] = pat;
      tick(4);
      chk({7'h00, fault_oe}, {7'h00, |pat[7:4]});
      chk({7'h00, fault_out_n}, 8'h00);
      rd(`OFS_FLAGS, 1);
      tick(4);
      chk({7'h00, fault_oe}, 8'h00);
      rd(`OFS_FLAGS, 1);
    end
    $display("test status done");
    conclude();
  end
endmodule
